// *** design/pifr_params.svh ***
/*
  Constants of the peripheral interrupt flag register: register indices,
  field positions, reset values and bus response codes.
  Assumes it is included by bare name wherever these constants are used.
*/
`ifndef PIFR_PARAMS_SVH
`define PIFR_PARAMS_SVH

// Bus address width and register indices; byte address is four times the index.
`define PIFR_ADDR_W 8
`define PIFR_FLAGS_IDX 8'h16
`define PIFR_CTRL_IDX 8'h17

// Flag positions within the flag register.
`define PIFR_BIT_PORT 7
`define PIFR_BIT_T3 6
`define PIFR_BIT_T2 5
`define PIFR_BIT_T1 4
`define PIFR_BIT_CAP2 3
`define PIFR_BIT_CAP1 2
`define PIFR_BIT_TX 1
`define PIFR_BIT_RX 0

// Control register fields.
`define PIFR_CTRL_RELATCH 0
`define PIFR_LATCH_LSB 8
`define PIFR_LATCH_MSB 15

// Reset values.
`define PIFR_RW_RST 6'h00
`define PIFR_TX_RST 1'h1
`define PIFR_RX_RST 1'h0
`define PIFR_FLAGS_RST 8'h02
`define PIFR_LATCH_RST 8'h00

// AXI responses.
`define PIFR_RESP_OKAY 2'h0
`define PIFR_RESP_SLVERR 2'h2

`endif

// *** design/pifr_pkg.sv ***
/*
  Types shared by the peripheral interrupt flag register design.
  Assumes pifr_params.svh is on the include path.
*/
`default_nettype none
`include "pifr_params.svh"

package pifr_pkg;

  typedef logic [7:0] pifr_byte_t;
  typedef logic [31:0] pifr_word_t;
  typedef logic [1:0] pifr_resp_t;

  // Word index of a byte address.
  function automatic pifr_byte_t pifr_word_idx(input logic [`PIFR_ADDR_W-1:0] addr);
    pifr_word_idx = {2'h0, addr[`PIFR_ADDR_W-1:2]};
  endfunction

endpackage

`default_nettype wire

// *** design/pifr_axil.sv ***
/*
  AXI4-Lite slave front end: takes write address and data in either order,
  issues a one-cycle register write strobe, and answers reads one cycle after
  the address is taken.
  Assumes one clock, a synchronous active-low reset, and a register file that
  decodes indices and returns read data combinationally.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pifr_params.svh"

module pifr_axil (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`PIFR_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`PIFR_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wr_en,
  output logic [7:0] wr_idx,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_hit,
  output logic [7:0] rd_idx,
  input wire logic [31:0] rd_data,
  input wire logic rd_hit
);

  logic aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [`PIFR_ADDR_W-1:0] addr_q;
  pifr_pkg::pifr_word_t data_q;
  logic [3:0] strb_q;
  logic awready_q, wready_q, bvalid_q, bvalid_d, arready_q, rvalid_q, rvalid_d;
  pifr_pkg::pifr_resp_t bresp_q, rresp_q;
  pifr_pkg::pifr_word_t rdata_q;
  wire logic aw_take, w_take, do_wr, ar_take;

  //////////////////////////////////////////////////////////////////////////////
  // Write path.

  assign aw_take = awvalid & awready_q;
  assign w_take = wvalid & wready_q;
  assign do_wr = aw_full_q & w_full_q & ~bvalid_q;
  assign aw_full_d = aw_take | (aw_full_q & ~do_wr);
  assign w_full_d = w_take | (w_full_q & ~do_wr);
  assign bvalid_d = do_wr | (bvalid_q & ~bready);

  assign wr_en = do_wr;
  assign wr_idx = pifr_pkg::pifr_word_idx(addr_q);
  assign wr_data = data_q;
  assign wr_strb = strb_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `PIFR_RESP_OKAY;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      awready_q <= ~aw_full_d;
      wready_q <= ~w_full_d;
      bvalid_q <= bvalid_d;
      if (do_wr) begin
        bresp_q <= wr_hit ? `PIFR_RESP_OKAY : `PIFR_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (aw_take) begin
      addr_q <= awaddr;
    end
    if (w_take) begin
      data_q <= wdata;
      strb_q <= wstrb;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path.

  assign ar_take = arvalid & arready_q;
  assign rvalid_d = ar_take | (rvalid_q & ~rready);
  assign rd_idx = pifr_pkg::pifr_word_idx(araddr);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `PIFR_RESP_OKAY;
    end else begin
      arready_q <= ~rvalid_d;
      rvalid_q <= rvalid_d;
      if (ar_take) begin
        rdata_q <= rd_hit ? rd_data : 32'h0000_0000;
        rresp_q <= rd_hit ? `PIFR_RESP_OKAY : `PIFR_RESP_SLVERR;
      end
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

endmodule

`default_nettype wire

// *** design/pifr_flags.sv ***
/*
  Peripheral interrupt flag register: gathers event strobes from the port
  change detector, three timers, two capture units and the serial buffers
  into one 8-bit flag register reachable over AXI4-Lite.
  Assumes all event inputs are synchronous to CLK, one-cycle strobes for
  timer and capture events and levels for the port and the serial buffers.
*/
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "pifr_params.svh"

module pifr_flags #(
  parameter int PORT_W = 8
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [`PIFR_ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [`PIFR_ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic [PORT_W-1:0] CHANGE_MONITORED_PORT,
  input wire logic CAPTURE1_MODE_SELECT,
  input wire logic T3_OVERFLOW,
  input wire logic T3_PERIOD_WRAP,
  input wire logic T2_PERIOD_WRAP,
  input wire logic TIMER1_WIDTH_SELECT,
  input wire logic T1_PERIOD_WRAP,
  input wire logic T12_CASCADE_WRAP,
  input wire logic CAPTURE1_EVENT,
  input wire logic CAPTURE2_EVENT,
  input wire logic TX_BUF_FULL,
  input wire logic RX_BUF_FULL,
  output logic [7:0] PERIPHERAL_IRQ_FLAGS
);

  logic [7:2] rw_q, rw_d;
  logic serial_tx_flag_q, serial_rx_flag_q;
  logic [PORT_W-1:0] port_latch_q;
  logic latch_init_q;
  wire logic wr_en, wr_hit, rd_hit, flags_wr, ctrl_wr, relatch, port_mismatch;
  wire logic [7:0] wr_idx, rd_idx;
  wire logic [31:0] wr_data, rd_data, ctrl_rd;
  wire logic [3:0] wr_strb;
  wire logic [7:2] set_ev, wr_val;
  wire pifr_pkg::pifr_byte_t flags_rd;

  // Register decode shared by the write path, the read path and the checks.
  function automatic logic is_flags(input pifr_pkg::pifr_byte_t idx);
    is_flags = (idx == `PIFR_FLAGS_IDX);
  endfunction

  function automatic logic is_mapped(input pifr_pkg::pifr_byte_t idx);
    is_mapped = is_flags(idx) | (idx == `PIFR_CTRL_IDX);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave.

  pifr_axil u_axil (
    .clk(CLK),
    .rst_n(RST_N),
    .awaddr(AWADDR),
    .awvalid(AWVALID),
    .awready(AWREADY),
    .wdata(WDATA),
    .wstrb(WSTRB),
    .wvalid(WVALID),
    .wready(WREADY),
    .bresp(BRESP),
    .bvalid(BVALID),
    .bready(BREADY),
    .araddr(ARADDR),
    .arvalid(ARVALID),
    .arready(ARREADY),
    .rdata(RDATA),
    .rresp(RRESP),
    .rvalid(RVALID),
    .rready(RREADY),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_hit(wr_hit),
    .rd_idx(rd_idx),
    .rd_data(rd_data),
    .rd_hit(rd_hit)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Register decode.

  assign wr_hit = is_mapped(wr_idx);
  assign rd_hit = is_mapped(rd_idx);
  assign flags_wr = wr_en & is_flags(wr_idx) & wr_strb[0];
  assign ctrl_wr = wr_en & (wr_idx == `PIFR_CTRL_IDX) & wr_strb[0];
  assign wr_val = wr_data[`PIFR_BIT_PORT:`PIFR_BIT_CAP1];

  // Read-only bits ignore writes; only the writable flags are stored.
  assign flags_rd = {rw_q, serial_tx_flag_q, serial_rx_flag_q};
  assign ctrl_rd = 32'(port_latch_q) << `PIFR_LATCH_LSB;
  assign rd_data = is_flags(rd_idx) ? {24'h00_0000, flags_rd} : ctrl_rd;

  //////////////////////////////////////////////////////////////////////////////
  // Port change detection.

  // The latch follows the port once after reset and again on software request,
  // so a mismatch that software has dealt with stops setting the flag.
  assign relatch = latch_init_q | (ctrl_wr & wr_data[`PIFR_CTRL_RELATCH]);
  assign port_mismatch = |(CHANGE_MONITORED_PORT ^ port_latch_q);

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      latch_init_q <= 1'b1;
      port_latch_q <= {PORT_W{1'b0}};
    end else begin
      latch_init_q <= 1'b0;
      if (relatch) begin
        port_latch_q <= CHANGE_MONITORED_PORT;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Event selection and flag storage.

  assign set_ev[`PIFR_BIT_PORT] = port_mismatch & ~relatch;
  assign set_ev[`PIFR_BIT_T3] = CAPTURE1_MODE_SELECT ? T3_OVERFLOW : T3_PERIOD_WRAP;
  assign set_ev[`PIFR_BIT_T2] = T2_PERIOD_WRAP;
  assign set_ev[`PIFR_BIT_T1] = TIMER1_WIDTH_SELECT ? T12_CASCADE_WRAP : T1_PERIOD_WRAP;
  assign set_ev[`PIFR_BIT_CAP2] = CAPTURE2_EVENT;
  assign set_ev[`PIFR_BIT_CAP1] = CAPTURE1_EVENT;

  // Enables and the global disable are not inputs here, so nothing masks a set.
  assign rw_d = set_ev | (flags_wr ? wr_val : rw_q);

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rw_q <= `PIFR_RW_RST;
      serial_tx_flag_q <= `PIFR_TX_RST;
      serial_rx_flag_q <= `PIFR_RX_RST;
    end else begin
      rw_q <= rw_d;
      serial_tx_flag_q <= ~TX_BUF_FULL;
      serial_rx_flag_q <= RX_BUF_FULL;
    end
  end

  assign PERIPHERAL_IRQ_FLAGS = {rw_q, serial_tx_flag_q, serial_rx_flag_q};

  //////////////////////////////////////////////////////////////////////////////
  // Assertions.

  property p_reset_value;
    @(posedge CLK) !RST_N |=> (PERIPHERAL_IRQ_FLAGS == `PIFR_FLAGS_RST);
  endproperty
  a_reset_flag_values: assert property (p_reset_value)
    else $error("flag register does not hold its reset value after reset");

  a_set_not_masked: assert property (@(posedge CLK) disable iff (!RST_N)
    (set_ev != 6'h00) |=> ((rw_q & $past(set_ev)) == $past(set_ev)))
    else $error("an event did not set its flag");

  a_flag_sticks: assert property (@(posedge CLK) disable iff (!RST_N)
    !flags_wr |=> ((rw_q & $past(rw_q)) == $past(rw_q)))
    else $error("a set flag dropped without a software write");

  a_write_clears: assert property (@(posedge CLK) disable iff (!RST_N)
    (flags_wr && set_ev == 6'h00) |=> (rw_q == $past(wr_val)))
    else $error("software write did not store the writable flags");

  a_set_beats_clear: assert property (@(posedge CLK) disable iff (!RST_N)
    (flags_wr && set_ev != 6'h00) |=> ((rw_q & $past(set_ev)) == $past(set_ev)))
    else $error("a clear in the event cycle won over the set");

  a_port_mismatch: assert property (@(posedge CLK) disable iff (!RST_N)
    (port_mismatch && !relatch) |=> rw_q[`PIFR_BIT_PORT])
    else $error("port mismatch did not set the port flag");

  a_port_quiet: assert property (@(posedge CLK) disable iff (!RST_N)
    (!port_mismatch && flags_wr && !wr_val[`PIFR_BIT_PORT]) |=> !rw_q[`PIFR_BIT_PORT])
    else $error("port flag set with no mismatch");

  a_t3_overflow: assert property (@(posedge CLK) disable iff (!RST_N)
    (CAPTURE1_MODE_SELECT && T3_OVERFLOW) |=> rw_q[`PIFR_BIT_T3])
    else $error("timer3 overflow in capture mode did not set its flag");

  a_t3_period: assert property (@(posedge CLK) disable iff (!RST_N)
    (!CAPTURE1_MODE_SELECT && T3_PERIOD_WRAP) |=> rw_q[`PIFR_BIT_T3])
    else $error("timer3 period wrap did not set its flag");

  a_t3_wrong_source: assert property (@(posedge CLK) disable iff (!RST_N)
    (!CAPTURE1_MODE_SELECT && !T3_PERIOD_WRAP && flags_wr && !wr_val[`PIFR_BIT_T3])
    |=> !rw_q[`PIFR_BIT_T3])
    else $error("timer3 flag set by the unselected source");

  a_t2_wrap: assert property (@(posedge CLK) disable iff (!RST_N)
    T2_PERIOD_WRAP |=> rw_q[`PIFR_BIT_T2])
    else $error("timer2 wrap did not set its flag");

  a_t1_narrow: assert property (@(posedge CLK) disable iff (!RST_N)
    (!TIMER1_WIDTH_SELECT && T1_PERIOD_WRAP) |=> rw_q[`PIFR_BIT_T1])
    else $error("timer1 8-bit wrap did not set its flag");

  a_t1_cascade: assert property (@(posedge CLK) disable iff (!RST_N)
    (TIMER1_WIDTH_SELECT && T12_CASCADE_WRAP) |=> rw_q[`PIFR_BIT_T1])
    else $error("cascaded timer wrap did not set the timer1 flag");

  a_t1_wrong_source: assert property (@(posedge CLK) disable iff (!RST_N)
    (TIMER1_WIDTH_SELECT && !T12_CASCADE_WRAP && flags_wr && !wr_val[`PIFR_BIT_T1])
    |=> !rw_q[`PIFR_BIT_T1])
    else $error("timer1 flag set by the 8-bit wrap in 16-bit mode");

  a_cap2_event: assert property (@(posedge CLK) disable iff (!RST_N)
    CAPTURE2_EVENT |=> rw_q[`PIFR_BIT_CAP2])
    else $error("capture2 event did not set its flag");

  a_cap1_event: assert property (@(posedge CLK) disable iff (!RST_N)
    CAPTURE1_EVENT |=> rw_q[`PIFR_BIT_CAP1])
    else $error("capture1 event did not set its flag");

  a_tx_mirror: assert property (@(posedge CLK) disable iff (!RST_N)
    1'b1 |=> (PERIPHERAL_IRQ_FLAGS[`PIFR_BIT_TX] == !$past(TX_BUF_FULL)))
    else $error("transmit flag does not mirror the transmit buffer");

  a_rx_mirror: assert property (@(posedge CLK) disable iff (!RST_N)
    RX_BUF_FULL[*2] |-> PERIPHERAL_IRQ_FLAGS[`PIFR_BIT_RX])
    else $error("receive flag low while the receive buffer holds a byte");

  a_read_flags: assert property (@(posedge CLK) disable iff (!RST_N)
    (ARVALID && ARREADY && rd_idx == `PIFR_FLAGS_IDX)
    |=> (RVALID && RDATA == {24'h00_0000, $past(flags_rd)}))
    else $error("flag read returned the wrong value");

  a_read_ctrl: assert property (@(posedge CLK) disable iff (!RST_N)
    (ARVALID && ARREADY && rd_idx == `PIFR_CTRL_IDX)
    |=> (RDATA == (32'($past(port_latch_q)) << `PIFR_LATCH_LSB)))
    else $error("control read did not return the latched port");

  a_read_miss: assert property (@(posedge CLK) disable iff (!RST_N)
    (ARVALID && ARREADY && !rd_hit)
    |=> (RDATA == 32'h0000_0000 && RRESP == `PIFR_RESP_SLVERR))
    else $error("unmapped read was not refused");

  a_read_answer: assert property (@(posedge CLK) disable iff (!RST_N)
    (ARVALID && ARREADY) |=> (RVALID && !ARREADY))
    else $error("read not answered one cycle after its address");

  a_read_closes: assert property (@(posedge CLK) disable iff (!RST_N)
    (RVALID && RREADY) |=> !RVALID)
    else $error("read answer stayed after its handshake");

  a_write_miss: assert property (@(posedge CLK) disable iff (!RST_N)
    (wr_en && !wr_hit) |=> (BVALID && BRESP == `PIFR_RESP_SLVERR))
    else $error("unmapped write was not refused");

  a_write_hit: assert property (@(posedge CLK) disable iff (!RST_N)
    (wr_en && wr_hit) |=> (BVALID && BRESP == `PIFR_RESP_OKAY))
    else $error("mapped write was not answered with okay");

  a_write_closes: assert property (@(posedge CLK) disable iff (!RST_N)
    (BVALID && BREADY) |=> !BVALID)
    else $error("write answer stayed after its handshake");

  a_strobe_gate: assert property (@(posedge CLK) disable iff (!RST_N)
    (wr_en && is_flags(wr_idx) && !wr_strb[0] && set_ev == 6'h00) |=> $stable(rw_q))
    else $error("write without its byte strobe changed the flags");

  a_ctrl_keeps_flags: assert property (@(posedge CLK) disable iff (!RST_N)
    (ctrl_wr && set_ev == 6'h00) |=> $stable(rw_q))
    else $error("control write changed the writable flags");

  a_latch_follows: assert property (@(posedge CLK) disable iff (!RST_N)
    (RST_N && relatch) |=> (port_latch_q == $past(CHANGE_MONITORED_PORT)))
    else $error("port latch did not take the port value");

  a_relatch_quiet: assert property (@(posedge CLK) disable iff (!RST_N)
    (relatch && !rw_q[`PIFR_BIT_PORT]) |=> !rw_q[`PIFR_BIT_PORT])
    else $error("a relatch edge set the port flag");

  a_t3_wrong_mode: assert property (@(posedge CLK) disable iff (!RST_N)
    (CAPTURE1_MODE_SELECT && !T3_OVERFLOW && flags_wr && !wr_val[`PIFR_BIT_T3])
    |=> !rw_q[`PIFR_BIT_T3])
    else $error("timer3 flag set by the period wrap in capture mode");

  a_t1_wrong_mode: assert property (@(posedge CLK) disable iff (!RST_N)
    (!TIMER1_WIDTH_SELECT && !T1_PERIOD_WRAP && flags_wr && !wr_val[`PIFR_BIT_T1])
    |=> !rw_q[`PIFR_BIT_T1])
    else $error("timer1 flag set by the cascade wrap in 8-bit mode");

  a_t2_quiet: assert property (@(posedge CLK) disable iff (!RST_N)
    (!T2_PERIOD_WRAP && flags_wr && !wr_val[`PIFR_BIT_T2]) |=> !rw_q[`PIFR_BIT_T2])
    else $error("timer2 flag set with no wrap");

  a_cap2_quiet: assert property (@(posedge CLK) disable iff (!RST_N)
    (!CAPTURE2_EVENT && flags_wr && !wr_val[`PIFR_BIT_CAP2]) |=> !rw_q[`PIFR_BIT_CAP2])
    else $error("capture2 flag set with no event");

  a_cap1_quiet: assert property (@(posedge CLK) disable iff (!RST_N)
    (!CAPTURE1_EVENT && flags_wr && !wr_val[`PIFR_BIT_CAP1]) |=> !rw_q[`PIFR_BIT_CAP1])
    else $error("capture1 flag set with no event");

  a_rx_empty: assert property (@(posedge CLK) disable iff (!RST_N)
    (!RX_BUF_FULL)[*2] |-> !PERIPHERAL_IRQ_FLAGS[`PIFR_BIT_RX])
    else $error("receive flag high while the receive buffer is empty");

  a_tx_full: assert property (@(posedge CLK) disable iff (!RST_N)
    TX_BUF_FULL[*2] |-> !PERIPHERAL_IRQ_FLAGS[`PIFR_BIT_TX])
    else $error("transmit flag high while the transmit buffer is full");

  c_set_and_clear: cover property (@(posedge CLK) disable iff (!RST_N)
    flags_wr && (set_ev & ~wr_val) != 6'h00);
  c_port_change: cover property (@(posedge CLK) disable iff (!RST_N)
    port_mismatch ##1 relatch ##1 !port_mismatch);
  c_cascade_wrap: cover property (@(posedge CLK) disable iff (!RST_N)
    TIMER1_WIDTH_SELECT && T12_CASCADE_WRAP);
  c_flag_read: cover property (@(posedge CLK) disable iff (!RST_N)
    RVALID && RREADY && RDATA[7:2] != 6'h00);
  c_t3_overflow: cover property (@(posedge CLK) disable iff (!RST_N)
    CAPTURE1_MODE_SELECT && T3_OVERFLOW);

endmodule

`default_nettype wire

// *** dv/pifr_periph_model.sv ***
/*
  Behavioural model of the peripherals around the flag register: timers,
  capture units, serial buffers and the change-monitored port.
  Assumes the bench calls its tasks and that all outputs follow the core clock.
*/
`timescale 1ns/100ps
`default_nettype none

module pifr_periph_model #(
  parameter int PORT_W = 8
) (
  input wire logic clk,
  output var logic [PORT_W-1:0] port_q,
  output var logic [6:0] strobe_q,
  output var logic tx_full_q,
  output var logic rx_full_q
);

  initial begin
    port_q = '0;
    strobe_q = '0;
    tx_full_q = 1'b0;
    rx_full_q = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event strobe idx rises dly edges after the call and stays for one cycle.
  task automatic pulse(input int idx, input int dly);
    repeat (dly) @(posedge clk);
    strobe_q[idx] <= 1'b1;
    @(posedge clk);
    strobe_q[idx] <= 1'b0;
  endtask

  // Port and buffer levels change together at the next edge.
  task automatic levels(input logic [PORT_W-1:0] p, input logic tf, input logic rf);
    @(posedge clk);
    port_q <= p;
    tx_full_q <= tf;
    rx_full_q <= rf;
  endtask

endmodule

`default_nettype wire

// *** dv/tb_pifr_flags.sv ***
/*
  Self-checking bench of the peripheral interrupt flag register.
  Assumes pifr_params.svh on the include path and the peripheral model beside it.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pifr_params.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end

module tb_pifr_flags;
  localparam logic [7:0] A_FLG = 8'(`PIFR_FLAGS_IDX << 2);
  localparam logic [7:0] A_CTL = 8'(`PIFR_CTRL_IDX << 2);
  // Step 0 sits in the lowest slot of each table.
  localparam logic [10:0][2:0] EV_IDX =
    {3'h5, 3'h6, 3'h3, 3'h4, 3'h4, 3'h3, 3'h2, 3'h0, 3'h1, 3'h1, 3'h0};
  localparam logic [10:0] EV_MODE = 11'h003;
  localparam logic [10:0] EV_WID = 11'h180;
  localparam logic [10:0][7:0] EV_MASK =
    {8'h04, 8'h08, 8'h00, 8'h10, 8'h00, 8'h10, 8'h20, 8'h00, 8'h40, 8'h00, 8'h40};
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [`PIFR_ADDR_W-1:0] AWADDR = '0;
  logic [`PIFR_ADDR_W-1:0] ARADDR = '0;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic [31:0] WDATA = 32'h0;
  logic [3:0] WSTRB = 4'h0;
  logic CAPTURE1_MODE_SELECT = 1'b0;
  logic TIMER1_WIDTH_SELECT = 1'b0;
  wire logic AWREADY, WREADY, BVALID, ARREADY, RVALID, txf, rxf;
  wire logic [1:0] BRESP, RRESP;
  wire logic [31:0] RDATA;
  wire logic [7:0] PERIPHERAL_IRQ_FLAGS, port_v;
  wire logic [6:0] stb;
  int err_total = 0;
  int n_checks = 0;

  pifr_flags #(.PORT_W(8)) pifr_flags_inst (.CLK, .RST_N, .AWADDR, .AWVALID, .AWREADY,
    .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID,
    .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .CHANGE_MONITORED_PORT(port_v),
    .CAPTURE1_MODE_SELECT, .T3_OVERFLOW(stb[0]), .T3_PERIOD_WRAP(stb[1]),
    .T2_PERIOD_WRAP(stb[2]), .TIMER1_WIDTH_SELECT, .T1_PERIOD_WRAP(stb[3]),
    .T12_CASCADE_WRAP(stb[4]), .CAPTURE1_EVENT(stb[5]), .CAPTURE2_EVENT(stb[6]),
    .TX_BUF_FULL(txf), .RX_BUF_FULL(rxf), .PERIPHERAL_IRQ_FLAGS);

  pifr_periph_model #(.PORT_W(8)) pifr_periph_model_inst (.clk(CLK), .port_q(port_v),
    .strobe_q(stb), .tx_full_q(txf), .rx_full_q(rxf));

  initial begin
    forever #10 CLK = ~CLK;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic guard(input int n);
    if (n >= 100) begin
      `CHK(n, 0)
      results();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    int n;
    bit aw;
    bit wd;
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= s;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    aw = 1;
    wd = 1;
    n = 0;
    while ((aw || wd) && n < 100) begin
      @(posedge CLK);
      n++;
      if (aw && AWREADY) begin
        AWVALID <= 1'b0;
        aw = 0;
      end
      if (wd && WREADY) begin
        WVALID <= 1'b0;
        wd = 0;
      end
    end
    do begin
      @(posedge CLK);
      n++;
    end while (!BVALID && n < 100);
    BREADY <= 1'b0;
    guard(n);
    `CHK(BRESP, er)
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (!ARREADY && n < 100);
    ARVALID <= 1'b0;
    do begin
      @(posedge CLK);
      n++;
    end while (!RVALID && n < 100);
    RREADY <= 1'b0;
    guard(n);
    `CHK(RDATA, ed)
    `CHK(RRESP, er)
  endtask

  task automatic fl(input logic [7:0] e);
    @(posedge CLK);
    #1;
    `CHK(PERIPHERAL_IRQ_FLAGS, e)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    fl(`PIFR_FLAGS_RST);
    rdchk(A_FLG, 32'h02, `PIFR_RESP_OKAY);
    $display("t_reset done");
  endtask

  // Every timer and capture strobe with every mode select; a source of the other mode must not set.
  task automatic t_events();
    for (int i = 0; i < 11; i++) begin
      wr(A_FLG, 32'h0, 4'h1, `PIFR_RESP_OKAY);
      CAPTURE1_MODE_SELECT <= EV_MODE[i];
      TIMER1_WIDTH_SELECT <= EV_WID[i];
      pifr_periph_model_inst.pulse(EV_IDX[i], 2 + i % 3);
      fl(8'h02 | EV_MASK[i]);
    end
    $display("t_events done");
  endtask

  task automatic t_sticky();
    pifr_periph_model_inst.pulse(2, 1);
    repeat (6) @(posedge CLK);
    fl(8'h26);
    wr(A_FLG, 32'hDC, 4'h1, `PIFR_RESP_OKAY);
    fl(8'hDE);
    // The strobe lands on the very edge that performs the clearing write.
    fork
      wr(A_FLG, 32'h0, 4'h1, `PIFR_RESP_OKAY);
      pifr_periph_model_inst.pulse(6, 2);
    join
    fl(8'h0A);
    wr(A_FLG, 32'h0, 4'hE, `PIFR_RESP_OKAY);
    fl(8'h0A);
    $display("t_sticky done");
  endtask

  task automatic t_buffers();
    wr(A_FLG, 32'h0, 4'h1, `PIFR_RESP_OKAY);
    pifr_periph_model_inst.levels(8'h00, 1'b1, 1'b1);
    fl(8'h01);
    wr(A_FLG, 32'hFF, 4'hF, `PIFR_RESP_OKAY);
    rdchk(A_FLG, 32'hFD, `PIFR_RESP_OKAY);
    wr(A_FLG, 32'h0, 4'h1, `PIFR_RESP_OKAY);
    pifr_periph_model_inst.levels(8'h00, 1'b0, 1'b0);
    fl(8'h02);
    $display("t_buffers done");
  endtask

  task automatic t_port();
    pifr_periph_model_inst.levels(8'h5A, 1'b0, 1'b0);
    fl(8'h82);
    wr(A_FLG, 32'h0, 4'h1, `PIFR_RESP_OKAY);
    fl(8'h82);
    wr(A_CTL, 32'h1, 4'h1, `PIFR_RESP_OKAY);
    wr(A_FLG, 32'h0, 4'h1, `PIFR_RESP_OKAY);
    fl(8'h02);
    rdchk(A_CTL, 32'h5A00, `PIFR_RESP_OKAY);
    $display("t_port done");
  endtask

  task automatic t_map();
    wr(8'h40, 32'hFF, 4'hF, `PIFR_RESP_SLVERR);
    rdchk(8'h40, 32'h0, `PIFR_RESP_SLVERR);
    fl(8'h02);
    $display("t_map done");
  endtask

  task automatic t_rerun();
    wr(A_FLG, 32'hFC, 4'h1, `PIFR_RESP_OKAY);
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    fl(`PIFR_FLAGS_RST);
    @(posedge CLK);
    RST_N <= 1'b1;
    rdchk(A_FLG, 32'h02, `PIFR_RESP_OKAY);
    $display("t_rerun done");
  endtask

  initial begin
    repeat (4) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (2) @(posedge CLK);
    t_reset();
    t_events();
    t_sticky();
    t_buffers();
    t_port();
    t_map();
    t_rerun();
    results();
  end

endmodule

`default_nettype wire
